// >>> inc/ssh_pkg.sv
// Constants, types and helpers of the screen switch block.
package ssh_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int          CLK_PERIOD_NS  = 25;
    localparam int          POLL_PERIOD_NS = 100000;
    localparam int          HOLD_PERIOD_NS = 10000;
    localparam logic [15:0] POLL_CYCLES    = 16'(POLL_PERIOD_NS / CLK_PERIOD_NS);
    localparam logic [15:0] HOLD_CYCLES    = 16'(HOLD_PERIOD_NS / CLK_PERIOD_NS);

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [3:0] REG_CTRL        = 4'h0;
    localparam logic [3:0] REG_CTRL_BASE   = 4'h1;
    localparam logic [3:0] REG_NOTIFY_BASE = 4'h2;
    localparam logic [3:0] REG_POLL        = 4'h3;
    localparam logic [3:0] REG_HOLD        = 4'h4;
    localparam logic [3:0] REG_DISPLAY     = 4'h5;
    localparam logic [3:0] REG_LAST        = 4'h6;
    localparam logic [3:0] REG_IRQ_STAT    = 4'h7;
    localparam logic [3:0] REG_IRQ_MASK    = 4'h8;
    localparam logic [3:0] REG_GROUP0      = 4'h9;
    localparam logic [3:0] REG_STATE       = 4'hD;
    localparam int         GROUP_ENTRIES   = 4;

    // ****************************************************************
    // Fields and reset values
    // ****************************************************************
    localparam int          CTRL_EN_BIT       = 0;
    localparam int          STATE_STROBE_BIT  = 0;
    localparam int          STATE_GROUP_BIT   = 1;
    localparam int          STATE_BUSY_BIT    = 2;
    localparam logic [15:0] CTRL_BASE_RST     = 16'h0100;
    localparam logic [15:0] NOTIFY_BASE_RST   = 16'h0110;
    localparam logic [15:0] STATUS_WORD_OFS   = 16'h0002;
    localparam int          SWITCH_STROBE_BIT = 12;
    localparam int          IRQ_W             = 3;
    localparam int          IRQ_SWITCH        = 0;
    localparam int          IRQ_BADNUM        = 1;
    localparam int          IRQ_CLEARED       = 2;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [2:0] {S_WAIT, S_READ, S_NOTIFY, S_HOLD, S_CLEAR} ssh_state_t;
    typedef enum logic {L_IDLE, L_BUSY} ssh_link_state_t;

    // True when all nibbles are decimal.
    function automatic logic sshBcdValid(input logic [15:0] v);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < 4; i++) begin
            if (v[4*i +: 4] > 4'h9) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

endpackage

// >>> inc/ssh_xfer_if.sv
// Carrier between the switch core and its link master.
`timescale 1ns/1ps
interface ssh_xfer_if;
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [15:0] dataA;
    logic [15:0] dataB;
    logic        done;
    logic [15:0] rdata;

    modport client (output req, output we, output addr, output dataA, output dataB,
                    input done, input rdata);
    modport agent  (input req, input we, input addr, input dataA, input dataB,
                    output done, output rdata);
endinterface

// >>> logic/ssh_link_master.sv
// Link master running one host memory transfer at a time.
`timescale 1ns/1ps
module ssh_link_master
    import ssh_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    ssh_xfer_if.agent        xfer,
    output logic             linkReq,
    output logic             linkWe,
    output logic [15:0]      linkAddr,
    output logic [15:0]      linkWdataA,
    output logic [15:0]      linkWdataB,
    input  wire logic        linkAck,
    input  wire logic [15:0] linkRdata
);

    typedef struct packed {
        ssh_link_state_t st;
        logic            req;
        logic            we;
        logic [15:0]     addr;
        logic [15:0]     dataA;
        logic [15:0]     dataB;
        logic            done;
        logic [15:0]     rdata;
    } ssh_link_t;

    ssh_link_t s;
    ssh_link_t next_s;

    // ****************************************************************
    // Transfer sequencing
    // ****************************************************************

    // Latched only when idle; the core waits for done first.
    always_comb begin
        next_s      = s;
        next_s.done = 1'b0;
        case (s.st)
            L_IDLE: begin
                if (xfer.req) begin
                    next_s.st    = L_BUSY;
                    next_s.req   = 1'b1;
                    next_s.we    = xfer.we;
                    next_s.addr  = xfer.addr;
                    next_s.dataA = xfer.dataA;
                    next_s.dataB = xfer.dataB;
                end
            end
            L_BUSY: begin
                if (linkAck) begin
                    next_s.st    = L_IDLE;
                    next_s.req   = 1'b0;
                    next_s.done  = 1'b1;
                    next_s.rdata = s.we ? s.rdata : linkRdata;
                end
            end
            default: begin
                next_s = '0;
            end
        endcase
    end

    // State register.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from the flops.
    assign linkReq    = s.req;
    assign linkWe     = s.we;
    assign linkAddr   = s.addr;
    assign linkWdataA = s.dataA;
    assign linkWdataB = s.dataB;
    assign xfer.done  = s.done;
    assign xfer.rdata = s.rdata;

endmodule

// >>> logic/ssh_screen_switch.sv
// Screen switch core with its register port.
//
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
// Contract
// R1 - Screen numbers in control and notify words are four-digit BCD.
// R2 - Displayed screen changes only when the control word value changes; the code also switches it on a touch press.
// R3 - Host writes zero first to reselect the same screen number.
// R4 - A controller-driven change also updates the notify word.
// R5 - Every change writes the new number and sets the switch strobe.
// R6 - The strobe returns to zero once the notification is delivered.
// R7 - A local touch-key change also updates notify word and raises strobe.
// R8 - A shown group reports its parent number in the notify word.
// R9 - A directly selected child screen is shown alone.
// R10 - Host reads the notify word whenever it sees the strobe set.
// R11 - Host copies the reported number into the control word on strobe rise.
// R12 - The first control-area word holds the requested screen number.
// R13 - Strobe set in the same update that writes the new number.
// R14 - Terminal polls the control word and compares with the last value.
module ssh_screen_switch
    import ssh_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire logic [3:0]  regAddr,
    input  wire logic [15:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [15:0] regRdata,
    input  wire logic        touchReq,
    input  wire logic [15:0] touchScreen,
    input  wire logic [15:0] touchParent,
    output logic      [15:0] dispScreen,
    output logic             dispGroup,
    output logic             irq,
    output logic             linkReq,
    output logic             linkWe,
    output logic      [15:0] linkAddr,
    output logic      [15:0] linkWdataA,
    output logic      [15:0] linkWdataB,
    input  wire logic        linkAck,
    input  wire logic [15:0] linkRdata
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        ssh_state_t                        st;
        logic                              ctrlEn;
        logic [15:0]                       ctrlBase;
        logic [15:0]                       notifyBase;
        logic [15:0]                       pollPeriod;
        logic [15:0]                       holdPeriod;
        logic [15:0]                       pollTimer;
        logic [15:0]                       holdTimer;
        logic [15:0]                       lastSeen;
        logic [15:0]                       dispScreen;
        logic                              dispGroup;
        logic [15:0]                       notifyNum;
        logic                              strobe;
        logic [IRQ_W-1:0]                  irqStat;
        logic [IRQ_W-1:0]                  irqMask;
        logic [GROUP_ENTRIES-1:0][15:0]    group;
        logic                              touchPend;
        logic [15:0]                       touchNum;
        logic [15:0]                       touchPar;
        logic [15:0]                       regRdata;
        logic                              xReq;
        logic                              xWe;
        logic [15:0]                       xAddr;
        logic [15:0]                       xDataA;
        logic [15:0]                       xDataB;
    } ssh_core_t;

    localparam ssh_core_t CORE_RST = '{
        st:         S_WAIT,
        ctrlBase:   CTRL_BASE_RST,
        notifyBase: NOTIFY_BASE_RST,
        pollPeriod: POLL_CYCLES,
        holdPeriod: HOLD_CYCLES,
        pollTimer:  POLL_CYCLES,
        default:    '0
    };

    ssh_core_t        s;
    ssh_core_t        next_s;
    logic [1:0]       rstPipe;
    logic             rst_n;
    logic [IRQ_W-1:0] events;
    logic             isParent;

    ssh_xfer_if xfer ();

    // ****************************************************************
    // Reset release
    // ****************************************************************

    // Released through two flops so all core flops leave reset
    // on the same edge.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rstPipe <= 2'h0;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end

    assign rst_n = rstPipe[1];

    // ****************************************************************
    // Group lookup
    // ****************************************************************

    // A control word names a group when it matches a parent
    // entry; zero entries never match.
    always_comb begin
        isParent = 1'b0;
        for (int i = 0; i < GROUP_ENTRIES; i++) begin
            if (s.group[i] != 16'h0000 && s.group[i] == xfer.rdata) begin
                isParent = 1'b1;
            end
        end
    end

    // ****************************************************************
    // Next state
    // ****************************************************************

    // Whole next state in one process.
    // Covers sequencer, registers, touch and interrupts.
    always_comb begin
        next_s          = s;
        next_s.xReq     = 1'b0;
        next_s.regRdata = 16'h0000;
        events          = '0;

        // The poll timer runs in every state so the rate
        // does not drift with notifications.
        if (s.pollTimer != 16'h0000) begin
            next_s.pollTimer = s.pollTimer - 16'h0001;
        end
        if (s.holdTimer != 16'h0000) begin
            next_s.holdTimer = s.holdTimer - 16'h0001;
        end

        case (s.st)
            S_WAIT: begin
                if (s.touchPend) begin
                    // Local key switch; a host copy-back is no change. [R7] [R11]
                    next_s.touchPend  = 1'b0;
                    next_s.dispScreen = s.touchNum;
                    next_s.dispGroup  = s.touchPar != 16'h0000;
                    next_s.notifyNum  = (s.touchPar != 16'h0000) ? s.touchPar : s.touchNum; // [R8]
                    next_s.lastSeen   = next_s.notifyNum;
                    next_s.xReq       = 1'b1;
                    next_s.xWe        = 1'b1;
                    next_s.xAddr      = s.notifyBase;
                    next_s.xDataA     = next_s.notifyNum;                     // [R5]
                    next_s.xDataB     = 16'h0001 << SWITCH_STROBE_BIT;        // [R13]
                    next_s.strobe     = 1'b1;
                    events[IRQ_SWITCH] = 1'b1;
                    next_s.st         = S_NOTIFY;
                end else if (s.ctrlEn && s.pollTimer == 16'h0000) begin
                    // Fetch the control word. [R12] [R14]
                    next_s.xReq      = 1'b1;
                    next_s.xWe       = 1'b0;
                    next_s.xAddr     = s.ctrlBase;
                    next_s.pollTimer = s.pollPeriod;
                    next_s.st        = S_READ;
                end
            end
            S_READ: begin
                if (xfer.done) begin
                    next_s.st = S_WAIT;
                    if (xfer.rdata != s.lastSeen) begin                       // [R2] [R14]
                        next_s.lastSeen = xfer.rdata;
                        if (xfer.rdata == 16'h0000) begin
                            // Zero only arms a reselection. [R3]
                            next_s.lastSeen = 16'h0000;
                        end else if (!sshBcdValid(xfer.rdata)) begin          // [R1]
                            events[IRQ_BADNUM] = 1'b1;
                        end else begin
                            // A parent shows its group. [R8] [R9]
                            next_s.dispScreen = xfer.rdata;
                            next_s.dispGroup  = isParent;
                            next_s.notifyNum  = xfer.rdata;
                            next_s.xReq       = 1'b1;
                            next_s.xWe        = 1'b1;
                            next_s.xAddr      = s.notifyBase;
                            next_s.xDataA     = xfer.rdata;                   // [R4] [R5]
                            next_s.xDataB     = 16'h0001 << SWITCH_STROBE_BIT; // [R13]
                            next_s.strobe     = 1'b1;
                            events[IRQ_SWITCH] = 1'b1;
                            next_s.st         = S_NOTIFY;
                        end
                    end
                end
            end
            S_NOTIFY: begin
                // Give the host time to poll the strobe.
                if (xfer.done) begin
                    next_s.holdTimer = s.holdPeriod;
                    next_s.st        = S_HOLD;
                end
            end
            S_HOLD: begin
                if (s.holdTimer == 16'h0000) begin
                    next_s.xReq   = 1'b1;
                    next_s.xWe    = 1'b1;
                    next_s.xAddr  = s.notifyBase;
                    next_s.xDataA = s.notifyNum;
                    next_s.xDataB = 16'h0000;                                 // [R6]
                    next_s.st     = S_CLEAR;
                end
            end
            S_CLEAR: begin
                if (xfer.done) begin
                    next_s.strobe       = 1'b0;                               // [R6]
                    events[IRQ_CLEARED] = 1'b1;
                    next_s.st           = S_WAIT;
                end
            end
            default: begin
                next_s.st = S_WAIT;
            end
        endcase

        // Touch requests latch at any time; a newer press
        // replaces a waiting one.
        if (touchReq) begin
            if (sshBcdValid(touchScreen) && sshBcdValid(touchParent)) begin   // [R1]
                next_s.touchPend = 1'b1;
                next_s.touchNum  = touchScreen;
                next_s.touchPar  = touchParent;
            end else begin
                events[IRQ_BADNUM] = 1'b1;
            end
        end

        // Register writes.
        if (regWr) begin
            case (regAddr)
                REG_CTRL:        next_s.ctrlEn     = regWdata[CTRL_EN_BIT];
                REG_CTRL_BASE:   next_s.ctrlBase   = regWdata;
                REG_NOTIFY_BASE: next_s.notifyBase = regWdata;
                REG_POLL:        next_s.pollPeriod = regWdata;
                REG_HOLD:        next_s.holdPeriod = regWdata;
                REG_IRQ_STAT:    next_s.irqStat    = s.irqStat & ~regWdata[IRQ_W-1:0];
                REG_IRQ_MASK:    next_s.irqMask    = regWdata[IRQ_W-1:0];
                default: begin
                    for (int i = 0; i < GROUP_ENTRIES; i++) begin
                        if (regAddr == REG_GROUP0 + 4'(i)) begin
                            next_s.group[i] = regWdata;
                        end
                    end
                end
            endcase
        end

        // Events are merged after the write-one-to-clear, so a set wins.
        next_s.irqStat = next_s.irqStat | events;

        // Register reads; unmapped words read as zero.
        if (regRd) begin
            case (regAddr)
                REG_CTRL:        next_s.regRdata = 16'(s.ctrlEn);
                REG_CTRL_BASE:   next_s.regRdata = s.ctrlBase;
                REG_NOTIFY_BASE: next_s.regRdata = s.notifyBase;
                REG_POLL:        next_s.regRdata = s.pollPeriod;
                REG_HOLD:        next_s.regRdata = s.holdPeriod;
                REG_DISPLAY:     next_s.regRdata = s.dispScreen;
                REG_LAST:        next_s.regRdata = s.lastSeen;
                REG_IRQ_STAT:    next_s.regRdata = 16'(s.irqStat);
                REG_IRQ_MASK:    next_s.regRdata = 16'(s.irqMask);
                REG_STATE: begin
                    next_s.regRdata[STATE_STROBE_BIT] = s.strobe;
                    next_s.regRdata[STATE_GROUP_BIT]  = s.dispGroup;
                    next_s.regRdata[STATE_BUSY_BIT]   = s.st != S_WAIT;
                end
                default: begin
                    for (int i = 0; i < GROUP_ENTRIES; i++) begin
                        if (regAddr == REG_GROUP0 + 4'(i)) begin
                            next_s.regRdata = s.group[i];
                        end
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************

    // Core state register.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= CORE_RST;
        end else begin
            s <= next_s;
        end
    end

    // ****************************************************************
    // Link master and outputs
    // ****************************************************************

    // Link requests come from flops.
    assign xfer.req   = s.xReq;
    assign xfer.we    = s.xWe;
    assign xfer.addr  = s.xAddr;
    assign xfer.dataA = s.xDataA;
    assign xfer.dataB = s.xDataB;

    ssh_link_master uLink (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .xfer       (xfer.agent),
        .linkReq    (linkReq),
        .linkWe     (linkWe),
        .linkAddr   (linkAddr),
        .linkWdataA (linkWdataA),
        .linkWdataB (linkWdataB),
        .linkAck    (linkAck),
        .linkRdata  (linkRdata)
    );

    // Level interrupt while any unmasked sticky bit is set.
    assign irq        = |(s.irqStat & s.irqMask);
    assign regRdata   = s.regRdata;
    assign dispScreen = s.dispScreen;
    assign dispGroup  = s.dispGroup;

endmodule

// >>> test/ssh_screen_switch_sva.sv
// Port checker for the screen switch handshake block.
`timescale 1ns/1ps
module ssh_screen_switch_sva (
    input logic        core_clk,
    input logic        arst_n,
    input logic [15:0] dispScreen,
    input logic        dispGroup,
    input logic        linkReq,
    input logic        linkWe,
    input logic [15:0] linkAddr,
    input logic [15:0] linkWdataA,
    input logic [15:0] linkWdataB,
    input logic        linkAck
);
    // One domain.
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);

    // Link and display checks.
    a_req_held: assert property (linkReq && !linkAck |=> linkReq && $stable(linkAddr)
        && $stable(linkWe)) else $error("request dropped");
    a_req_ends: assert property (linkReq && linkAck |=> !linkReq)
        else $error("request held");
    a_strobe_num: assert property (linkReq && linkWe && linkWdataB[12] |->
        linkWdataA == dispScreen || dispGroup) else $error("strobe number wrong");
    a_status_exact: assert property (linkReq && linkWe |->
        linkWdataB == 16'h1000 || linkWdataB == 16'h0000) else $error("bad status word");
    a_disp_notify: assert property ($changed(dispScreen) |->
        ##[0:4] (linkReq && linkWe && linkWdataB[12])) else $error("switch not notified");
    a_clear_follows: assert property (linkReq && linkWe && linkWdataB[12] && linkAck
        |-> ##[1:1000] (linkReq && linkWe && linkWdataB == 16'h0000))
        else $error("strobe never cleared");
    a_clear_num: assert property (linkReq && linkWe && linkWdataB == 16'h0000 |->
        linkWdataA == dispScreen || dispGroup) else $error("clear number wrong");
    a_disp_bcd: assert property (dispScreen[3:0] <= 4'h9 && dispScreen[7:4] <= 4'h9 &&
        dispScreen[11:8] <= 4'h9 && dispScreen[15:12] <= 4'h9) else $error("screen not BCD");
endmodule

bind ssh_screen_switch ssh_screen_switch_sva chk (.core_clk, .arst_n, .dispScreen,
    .dispGroup, .linkReq, .linkWe, .linkAddr, .linkWdataA, .linkWdataB, .linkAck);

// >>> test/ssh_host_model.sv
// Host controller model with control, notify and status words.
`timescale 1ns/1ps
module ssh_host_model (
    input  wire logic        core_clk,
    input  wire logic        slow,
    input  wire logic        copyBack,
    input  wire logic        setReq,
    input  wire logic [15:0] setVal,
    input  wire logic        linkReq,
    input  wire logic        linkWe,
    input  wire logic [15:0] linkAddr,
    input  wire logic [15:0] linkWdataA,
    input  wire logic [15:0] linkWdataB,
    output logic             linkAck,
    output logic      [15:0] linkRdata
);
    logic [15:0] ctrlWord   = 16'h0000;
    logic [15:0] notifyWord = 16'h0000;
    logic [15:0] statusWord = 16'h0000;
    logic [15:0] readAddr   = 16'h0000;
    logic [15:0] writeAddr  = 16'h0000;
    int          setCount   = 0;
    int          waitCnt    = 0;

    initial begin
        linkAck = 1'b0;
        linkRdata = 16'hFFFF;
    end

    // Acks after one or six cycles; idle read data shows the inverse.
    always @(posedge core_clk) begin
        linkAck <= 1'b0;
        linkRdata <= ~linkRdata;
        if (setReq) begin
            ctrlWord <= setVal;
        end
        if (linkReq && !linkAck) begin
            waitCnt <= waitCnt + 1;
            if (waitCnt >= (slow ? 5 : 0)) begin
                linkAck <= 1'b1;
                waitCnt <= 0;
                if (linkWe) begin
                    writeAddr <= linkAddr;
                    notifyWord <= linkWdataA;
                    statusWord <= linkWdataB;
                    if (linkWdataB[12]) begin
                        setCount <= setCount + 1;
                    end
                    if (copyBack && linkWdataB[12] && !statusWord[12]) begin
                        ctrlWord <= linkWdataA;
                    end
                end else begin
                    readAddr <= linkAddr;
                    linkRdata <= ctrlWord;
                end
            end
        end
    end
endmodule

// >>> test/tb.sv
// Self-checking bench for the screen switch block.
`timescale 1ns/1ps
module tb;
    import ssh_pkg::*;
    logic        core_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [3:0]  regAddr = 4'h0;
    logic [15:0] regWdata = 16'h0000;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    logic        touchReq = 1'b0;
    logic [15:0] touchScreen = 16'h0000;
    logic [15:0] touchParent = 16'h0000;
    logic        slow = 1'b0;
    logic        copyBack = 1'b0;
    logic        setReq = 1'b0;
    logic [15:0] setVal = 16'h0000;
    logic [15:0] regRdata, dispScreen, linkAddr, linkWdataA, linkWdataB, linkRdata;
    logic        dispGroup, irq, linkReq, linkWe, linkAck;
    int          err_total = 0;
    int          checks = 0;

    ssh_screen_switch dut (.core_clk, .arst_n, .regAddr, .regWdata, .regWr, .regRd,
        .regRdata, .touchReq, .touchScreen, .touchParent, .dispScreen, .dispGroup, .irq,
        .linkReq, .linkWe, .linkAddr, .linkWdataA, .linkWdataB, .linkAck, .linkRdata);
    ssh_host_model host (.core_clk, .slow, .copyBack, .setReq, .setVal, .linkReq, .linkWe,
        .linkAddr, .linkWdataA, .linkWdataB, .linkAck, .linkRdata);

    always #12.5 core_clk = ~core_clk;

    task automatic print_verdict();
        if (err_total == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge core_clk);
        regWr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge core_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1;
        chk(regRdata, e);
    endtask

    task automatic host_set(input logic [15:0] v);
        @(posedge core_clk);
        setReq <= 1'b1;
        setVal <= v;
        @(posedge core_clk);
        setReq <= 1'b0;
    endtask

    // Waits for a set and clear handshake; the first poll may take 4000 cycles.
    task automatic wait_set(input int n);
        int i;
        for (i = 0; i < 5000; i++) begin
            @(posedge core_clk);
            if (host.setCount >= n && host.statusWord === 16'h0000 && linkReq === 1'b0) break;
        end
        #1;
        if (i == 5000) begin
            err_total++;
            print_verdict();
        end
    endtask

    task automatic t_regs();
        rd(REG_CTRL_BASE, 16'h0100);
        rd(REG_NOTIFY_BASE, 16'h0110);
        rd(REG_POLL, 16'h0FA0);
        rd(REG_HOLD, 16'h0190);
        rd(4'hE, 16'h0000);
        wr(REG_POLL, 16'h0014);
        wr(REG_HOLD, 16'h0005);
        wr(REG_IRQ_MASK, 16'h0007);
        wr(REG_CTRL, 16'h0001);
    endtask

    task automatic t_host();
        host_set(16'h0002);
        wait_set(1);
        chk(dispScreen, 16'h0002);
        chk(host.notifyWord, 16'h0002);
        chk(host.readAddr, 16'h0100);
        chk(host.writeAddr, 16'h0110);
        chk(16'(irq), 16'h0001);
        rd(REG_IRQ_STAT, 16'h0005);
        wr(REG_IRQ_STAT, 16'h0007);
        chk(16'(irq), 16'h0000);
        slow <= 1'b1;
        host_set(16'h0002);
        repeat (200) @(posedge core_clk);
        chk(16'(host.setCount), 16'h0001);
        host_set(16'h0000);
        repeat (100) @(posedge core_clk);
        chk(dispScreen, 16'h0002);
        host_set(16'h0002);
        wait_set(2);
        chk(16'(host.setCount), 16'h0002);
        slow <= 1'b0;
    endtask

    task automatic t_group();
        host_set(16'h00A1);
        repeat (200) @(posedge core_clk);
        chk(16'(host.setCount), 16'h0002);
        rd(REG_IRQ_STAT, 16'h0007);
        wr(REG_IRQ_STAT, 16'h0007);
        wr(REG_GROUP0, 16'h0005);
        host_set(16'h0005);
        wait_set(3);
        chk(16'(dispGroup), 16'h0001);
        host_set(16'h0006);
        wait_set(4);
        chk(16'(dispGroup), 16'h0000);
        chk(dispScreen, 16'h0006);
    endtask

    task automatic t_touch();
        copyBack <= 1'b1;
        @(posedge core_clk);
        touchReq <= 1'b1;
        touchScreen <= 16'h0007;
        touchParent <= 16'h0005;
        @(posedge core_clk);
        touchReq <= 1'b0;
        wait_set(5);
        chk(dispScreen, 16'h0007);
        chk(host.notifyWord, 16'h0005);
        chk(host.ctrlWord, 16'h0005);
        repeat (200) @(posedge core_clk);
        chk(16'(host.setCount), 16'h0005);
    endtask

    // Reset for 16 cycles; access waits out the synchroniser.
    initial begin
        repeat (16) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        t_regs();
        t_host();
        t_group();
        t_touch();
        print_verdict();
    end
endmodule
